// ---- design/cell_voltage_result_regs.sv ----
// Cell one to four voltage result registers behind an AHB-Lite slave
// Operation
// - Each cell's 14-bit result sits in bits 15:2 of its own register
// - Full result code range stands for a 5 V cell input
// - Disabled cell skipped in a scan keeps its stored data
// - Skipped disabled cell reads back raw or filtered value per select bit
// - Result registers are read only; writes leave them unchanged
//
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "cell_result_consts.svh"
module cell_voltage_result_regs (
    input wire logic clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic scanValid,
    input wire cell_result_pkg::cell_idx_t scanCell,
    input wire cell_result_pkg::result_t aluResult,
    input wire cell_result_pkg::result_t filtResult
);
    // Register word index from a byte address
    function automatic logic [7:0] wordIndex(input logic [31:0] addr);
        wordIndex = addr[9:2];
    endfunction

    logic dataRead_r;
    logic dataWrite_r;
    logic [31:0] addr_r;
    logic [3:0] cellEnable_r;
    logic filtSelect_r;
    logic [31:0] rdData_r;
    logic [31:0] rdData_nxt;
    logic [3:0] updateCount_r;
    wire logic transfer;
    wire logic [7:0] idx;
    wire logic isResult;
    wire cell_result_pkg::cell_idx_t rdCell;
    wire cell_result_pkg::result_t rdValue;
    wire logic ctrlWrite;
    wire logic inRange;
    wire logic wrInRange;

    // Address phase capture
    assign transfer = hsel && hready && (htrans == `HTRANS_NONSEQ || htrans == `HTRANS_SEQ);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dataRead_r <= 1'b0;
            dataWrite_r <= 1'b0;
            addr_r <= 32'h00000000;
        end else begin
            dataRead_r <= transfer && !hwrite;
            dataWrite_r <= transfer && hwrite;
            if (transfer) begin
                addr_r <= haddr;
            end
        end
    end

    // Read address decode; upper address bits must be clear so nothing aliases
    assign inRange = haddr[31:10] == 22'h000000;
    assign wrInRange = addr_r[31:10] == 22'h000000;
    assign idx = wordIndex(haddr);
    assign isResult = inRange && idx >= `FIRST_CELL_IDX && idx <= `FOURTH_CELL_IDX;
    assign rdCell = cell_result_pkg::cell_idx_t'(idx - `FIRST_CELL_IDX);

    // Only control writes land; result addresses ignore writes
    assign ctrlWrite = dataWrite_r && wrInRange && addr_r[9:0] == `CELL_CTRL_ADDR;

    // Control register: measure enables and filtered readback select
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cellEnable_r <= `ENABLE_RESET;
            filtSelect_r <= 1'b0;
        end else if (ctrlWrite) begin
            cellEnable_r <= hwdata[3:0];
            filtSelect_r <= hwdata[`FILT_SEL_BIT];
        end
    end

    // Count of accepted scan updates, for status
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            updateCount_r <= 4'h0;
        end else if (scanValid && cellEnable_r[scanCell]) begin
            updateCount_r <= updateCount_r + 4'h1;
        end
    end

    // Result storage; code already scaled so full range is 5 V
    cell_result_store store (
        .clk(clk),
        .rst(rst),
        .wrValid(scanValid),
        .wrCell(scanCell),
        .cellEnable(cellEnable_r[scanCell]),
        .aluValue(aluResult),
        .filtValue(filtResult),
        .filtSelect(filtSelect_r),
        .rdCell(rdCell),
        .rdValue(rdValue)
    );

    // Read mux; low two bits of results forced to zero
    always_comb begin
        rdData_nxt = 32'h00000000;
        if (isResult) begin
            rdData_nxt[`RESULT_MSB:`RESULT_LSB] = rdValue;
        end else if (inRange && haddr[9:0] == `CELL_CTRL_ADDR) begin
            rdData_nxt[3:0] = cellEnable_r;
            rdData_nxt[`FILT_SEL_BIT] = filtSelect_r;
        end else if (inRange && haddr[9:0] == `CELL_STATUS_ADDR) begin
            rdData_nxt[3:0] = updateCount_r;
        end
    end

    // Read data registered at address phase
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdData_r <= 32'h00000000;
        end else if (transfer && !hwrite) begin
            rdData_r <= rdData_nxt;
        end
    end

    assign hrdata = rdData_r;
    assign hreadyout = 1'b1; // Zero wait states
    assign hresp = 1'b0; // Always OKAY
endmodule

// ---- common/cell_result_consts.svh ----
// Register offsets, field positions and reset values for the cell result bank
`ifndef CELL_RESULT_CONSTS_SVH
`define CELL_RESULT_CONSTS_SVH
// Printed register indices (byte address is four times the index)
`define FIRST_CELL_IDX 8'h47
`define SECOND_CELL_IDX 8'h48
`define THIRD_CELL_IDX 8'h49
`define FOURTH_CELL_IDX 8'h4a
// Block control registers, byte addresses
`define CELL_CTRL_ADDR 10'h000
`define CELL_STATUS_ADDR 10'h004
// Field layout
`define RESULT_MSB 15
`define RESULT_LSB 2
`define RESULT_W 14
`define CELL_COUNT 4
`define RESULT_RESET 14'h0000
`define ENABLE_RESET 4'hf
`define FILT_SEL_BIT 4
// Full-scale cell input in millivolts for a full code range
`define FULL_SCALE_MV 5000
// AHB-Lite codes
`define HTRANS_NONSEQ 2'h2
`define HTRANS_SEQ 2'h3
`define HSIZE_WORD 3'h2
`endif

// ---- common/cell_result_pkg.sv ----
// Types for the cell result bank
package cell_result_pkg;
    typedef logic [13:0] result_t;
    typedef logic [1:0] cell_idx_t;
    typedef enum logic [1:0] {
        SCAN_IDLE = 2'b00,
        SCAN_RUN = 2'b01
    } scan_state_t;
endpackage

// ---- design/cell_result_store.sv ----
// Per-cell storage of raw and filtered results
`timescale 1ns/1ps
`include "cell_result_consts.svh"
module cell_result_store (
    input wire logic clk,
    input wire logic rst,
    input wire logic wrValid,
    input wire cell_result_pkg::cell_idx_t wrCell,
    input wire logic cellEnable,
    input wire cell_result_pkg::result_t aluValue,
    input wire cell_result_pkg::result_t filtValue,
    input wire logic filtSelect,
    input wire cell_result_pkg::cell_idx_t rdCell,
    output cell_result_pkg::result_t rdValue
);
    cell_result_pkg::result_t aluMem_r [`CELL_COUNT];
    cell_result_pkg::result_t filtMem_r [`CELL_COUNT];
    wire logic doUpdate;

    // A disabled, skipped cell keeps its stored data
    assign doUpdate = wrValid && cellEnable;

    // Storage update
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < `CELL_COUNT; i++) begin
                aluMem_r[i] <= `RESULT_RESET;
                filtMem_r[i] <= `RESULT_RESET;
            end
        end else if (doUpdate) begin
            aluMem_r[wrCell] <= aluValue;
            filtMem_r[wrCell] <= filtValue;
        end
    end

    // Readback source chosen by the filter select
    assign rdValue = filtSelect ? filtMem_r[rdCell] : aluMem_r[rdCell];
endmodule

// ---- dv/cell_voltage_result_regs_assertions.sv ----
// Bus-side checker for the cell result register bank
`timescale 1ns/1ps
module cell_voltage_result_regs_assertions (
    input wire logic clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic scanValid
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Accepted transfers, and those aimed at result registers
    wire logic req = hsel && hready && htrans[1];
    wire logic res = haddr >= 32'h11c && haddr <= 32'h128;
    wire logic rd = req && !hwrite && res && !scanValid;
    wire logic wr = req && hwrite && res && !scanValid;
    property p_lowZero; req && !hwrite && res |=> hrdata[1:0] == 2'h0; endproperty
    a_lowZero: assert property (p_lowZero) else $error("low bits not zero");
    property p_upZero; rd |=> hrdata[31:16] == 16'h0; endproperty
    a_upZero: assert property (p_upZero) else $error("upper bits not zero");
    property p_reread;
        !(req && hwrite) ##1 rd ##1 (!req && !scanValid) ##1 (rd && haddr == $past(haddr, 2)) |=> $stable(hrdata);
    endproperty
    a_reread: assert property (p_reread) else $error("result changed without scan");
    property p_wrIgnored;
        rd ##1 (!req && !scanValid) ##1 wr ##1 (!req && !scanValid) ##1 (rd && haddr == $past(haddr, 4))
            |=> hrdata == $past(hrdata);
    endproperty
    a_wrIgnored: assert property (p_wrIgnored) else $error("write changed result");
    property p_idleHold; (req && !hwrite) ##1 !req |=> $stable(hrdata); endproperty
    a_idleHold: assert property (p_idleHold) else $error("read data not held");
    property p_okay; req |-> hreadyout && !hresp; endproperty
    a_okay: assert property (p_okay) else $error("transfer not answered okay");
    c_read: cover property (rd);
    c_write: cover property (wr);
    c_scanRead: cover property (scanValid ##1 rd);
endmodule
bind cell_voltage_result_regs cell_voltage_result_regs_assertions cell_voltage_result_regs_assertions_inst (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .scanValid(scanValid));

// ---- dv/tb_top.sv ----
// Random and corner tests of the cell result register bank
`timescale 1ns/1ps
`include "cell_result_consts.svh"
module tb_top;
    logic clk = 0, rst = 1, hsel = 0, hwrite = 0, hreadyout, hresp, scanValid = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = `HSIZE_WORD;
    cell_result_pkg::cell_idx_t scanCell = 0, c;
    cell_result_pkg::result_t aluResult = 0, filtResult = 0, av, fv, aluM[4], fltM[4];
    logic [4:0] ctl = 5'h0f;
    logic [3:0] nUp = 4'h0;
    int errTotal = 0, nChecks = 0;
    cell_voltage_result_regs cell_voltage_result_regs_inst (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .scanValid(scanValid), .scanCell(scanCell),
        .aluResult(aluResult), .filtResult(filtResult));
    // Clock of 20 ns
    always #10 clk = ~clk;
    task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= `HTRANS_NONSEQ;
        do @(posedge clk); while (!hreadyout);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
        do @(posedge clk); while (!hreadyout);
        r = hrdata;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        nChecks++;
        if (seen !== exp) begin
            errTotal++;
            $display("ERROR hrdata expected %h seen %h", exp, seen);
        end
    endtask
    function automatic logic [31:0] cellAddr(input cell_result_pkg::cell_idx_t k);
        return {22'h0, `FIRST_CELL_IDX + 8'(k), 2'h0};
    endfunction
    // Expected read value from the bench's own copy of the cells
    function automatic logic [31:0] expv(input cell_result_pkg::cell_idx_t k);
        return {16'h0, ctl[`FILT_SEL_BIT] ? fltM[k] : aluM[k], 2'h0};
    endfunction
    task automatic give_verdict;
        $display("checks %0d errors %0d", nChecks, errTotal);
        if (errTotal == 0 && nChecks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Watchdog
    initial begin
        #100000;
        errTotal++;
        give_verdict;
    end
    // Main sequence
    initial begin
        void'($urandom(32'hbec1efee));
        for (int i = 0; i < 4; i++) begin
            aluM[i] = 14'h0;
            fltM[i] = 14'h0;
        end
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 4; i++) begin
            bus(cellAddr(2'(i)), 1'b0, 32'h0, q); chk(q, 32'h0);
        end
        bus(`CELL_CTRL_ADDR, 1'b0, 32'h0, q); chk(q, {28'h0, `ENABLE_RESET});
        for (int n = 0; n < 40; n++) begin
            c = 2'($urandom);
            av = (n == 0) ? 14'h3fff : 14'($urandom);
            fv = (n == 1) ? 14'h0001 : 14'($urandom);
            if (n % 4 == 3) begin
                ctl = 5'($urandom);
                bus(`CELL_CTRL_ADDR, 1'b1, {27'h0, ctl}, q);
                bus(`CELL_CTRL_ADDR, 1'b0, 32'h0, q); chk(q, {27'h0, ctl});
            end
            scanValid <= 1'b1; scanCell <= c; aluResult <= av; filtResult <= fv;
            @(posedge clk);
            scanValid <= 1'b0;
            if (ctl[c]) begin
                aluM[c] = av; fltM[c] = fv;
                nUp = nUp + 4'h1;
            end
            bus(cellAddr(c), 1'b0, 32'h0, q); chk(q, expv(c));
            bus(cellAddr(c), 1'b0, 32'h0, q); chk(q, expv(c));
            bus(cellAddr(c), 1'b1, $urandom, q);
            bus(cellAddr(c), 1'b0, 32'h0, q); chk(q, expv(c));
        end
        bus(32'h200, 1'b0, 32'h0, q); chk(q, 32'h0);
        bus(32'h400, 1'b0, 32'h0, q); chk(q, 32'h0);
        bus(32'h4, 1'b0, 32'h0, q); chk(q, {28'h0, nUp});
        give_verdict;
    end
endmodule
